// *** gprp_alu_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module gprp_alu_model (
  // Clock and reset
  input wire logic clk, rstn,
  // Issue handshake
  input wire logic issue_ready,
  output logic issue_valid,
  output logic [42:0] fld,
  output logic [7:0] stalls
);
  logic [42:0] q[$];
  // Released fields invert so stale values never pass as live
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      issue_valid <= 1'h0;
      fld <= '0;
      stalls <= 8'h0;
    end else if (issue_valid && !issue_ready) begin
      stalls <= stalls + 8'h1;
    end else if (q.size() > 0) begin
      issue_valid <= 1'h1;
      fld <= q.pop_front();
    end else begin
      issue_valid <= 1'h0;
      if (issue_valid) fld <= ~fld;
    end
  end
endmodule
`default_nettype wire

// *** gprp_consts.vh ***
`ifndef GPRP_CONSTS_VH
`define GPRP_CONSTS_VH

// Register byte offsets
`define GPRP_CFG_OFF     8'h00
`define GPRP_STAT_OFF    8'h04
`define GPRP_PRED_LO_OFF 8'h08
`define GPRP_PRED_HI_OFF 8'h0c
`define GPRP_ACT_LO_OFF  8'h10
`define GPRP_ACT_HI_OFF  8'h14
`define GPRP_VAL_LO_OFF  8'h18
`define GPRP_VAL_HI_OFF  8'h1c

// Configuration fields
`define GPRP_CFG_GLB_LSB 0
`define GPRP_CFG_GLB_MSB 7
`define GPRP_CFG_CT_LSB  8
`define GPRP_CFG_CT_MSB  10
`define GPRP_CFG_DYN_BIT 16
`define GPRP_STAT_ERR_BIT 16
`define GPRP_CFG_RESET   32'h0000_0000

// Addressable register numbers
`define GPRP_REG_SPAN    10'h080
`define GPRP_CT_MAX      3'h4

// Operand addressing modes
`define GPRP_MD_REL      2'h0
`define GPRP_MD_ABS      2'h1
`define GPRP_MD_IDX_OFF  2'h2
`define GPRP_MD_IDX_AR   2'h3

// Pixel state codes
`define GPRP_PS_ACTIVE   2'h0
`define GPRP_PS_IN_BRANCH 2'h1
`define GPRP_PS_IN_CONT  2'h2
`define GPRP_PS_IN_BREAK 2'h3

`endif

// *** gprp_partition.v ***
// Operation
// - Absolute mode: register number is physical 0-127
// - Otherwise relative to wavefront's allocated base
// - Globals limited to 128 minus twice temporaries
// - Globals removed from private register pool
// - Config register holds global count; agent programs
// - Absolute mode chosen per operand independently
// - Indexed: number plus offset or address X
// - Even and odd temporaries in separate sections
// - Stall cross-wavefront read of unretired global write
// - Top register numbers select clause temporaries
// - Temporaries need not survive between clauses
// - First slot of a wavefront is odd
// - Physical order global, temporaries, private
// - Globals plus temporaries fit lowest 128
// - Globals only in dynamic allocation mode
// - Predicate 64 bits, per clause, gates writes
// - Active mask takes predicate set at clause end
// - Valid mask updated by pixel kill instruction
// - Valid and active masks equal width
// - Two-bit state per pixel, four states
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "gprp_consts.vh"

module gprp_partition #(
  parameter PIX = 64,
  parameter [9:0] POOL = 10'h100
) (
  // Clock and reset
  input wire ref_clk,
  input wire rstn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // Operand issue
  input wire issue_valid,
  input wire issue_first,
  output wire issue_ready,
  input wire [8:0] wave_base,
  input wire [6:0] src_num,
  input wire [1:0] src_mode,
  input wire [6:0] src_off,
  input wire [6:0] dst_num,
  input wire [1:0] dst_mode,
  input wire [6:0] dst_off,
  input wire dst_we,
  input wire pred_use,
  // Address register load
  input wire address_load_move,
  input wire [8:0] addr_x_data,
  // Translated operands
  output reg out_valid,
  output reg out_odd,
  output reg [9:0] src_phys,
  output reg src_ct,
  output reg [9:0] dst_phys,
  output reg dst_ct,
  output reg [PIX-1:0] wr_mask,
  // Clause and pixel control
  input wire wave_start,
  input wire alu_clause_launch,
  input wire clause_end,
  input wire load_active,
  input wire pred_we,
  input wire [PIX-1:0] pred_lanes,
  input wire [PIX-1:0] pred_val,
  input wire predicate_set_ops,
  input wire pixel_kill_instruction,
  input wire [PIX-1:0] kill_lanes,
  input wire pstate_we,
  input wire [PIX-1:0] pstate_lanes,
  input wire [1:0] pstate_code,
  // Mask and state view
  output wire [PIX-1:0] pred_mask,
  output wire [PIX-1:0] active_mask,
  output wire [PIX-1:0] valid_mask,
  output wire [2*PIX-1:0] pixel_state
);

  ////////////////////////////////////////////////////////////////////////////
  reg [7:0] glb_cfg_q;
  reg [2:0] ct_cfg_q;
  reg dyn_q;
  reg err_q;
  reg [8:0] addr_x_q;
  reg slot_odd_q;
  reg pend_v_q;
  reg pend_odd_q;
  reg [9:0] pend_addr_q;
  reg [PIX-1:0] pred_q;
  reg [PIX-1:0] pset_q;
  reg [PIX-1:0] active_q;
  // Valid shares PIX with active, so the widths cannot drift apart
  reg [PIX-1:0] valid_q;
  reg [2*PIX-1:0] ps_q;

  wire [9:0] glb_lim;
  wire [7:0] glb_eff;
  wire [9:0] priv_avail;
  wire cur_odd;
  wire [10:0] src_x;
  wire [10:0] dst_x;
  wire src_glb;
  wire dst_glb;
  wire stall;
  wire setup;
  wire wr_acc;
  wire err_set;

  // Full reset word kept; only the fields below are stored
  localparam [31:0] CFG_RST = `GPRP_CFG_RESET;

  // Room left for globals after both temporary sections
  assign glb_lim = `GPRP_REG_SPAN - {6'h0, ct_cfg_q, 1'b0};
  assign glb_eff = ({2'h0, glb_cfg_q} > glb_lim) ? glb_lim[7:0] : glb_cfg_q;
  assign priv_avail = POOL - {2'h0, glb_eff} - {6'h0, ct_cfg_q, 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // Non-relative modes reach the shared space only in dynamic mode
  function shared_sel;
    input [1:0] md;
    input dyn;
    begin
      shared_sel = (md != `GPRP_MD_REL) && dyn;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Maps one operand to {temp flag, physical address}
  function [10:0] xlate;
    input [6:0] rn;
    input [1:0] md;
    input [6:0] off;
    input [8:0] arx;
    input [8:0] wb;
    input [7:0] g;
    input [2:0] t;
    input odd;
    input dyn;
    reg [9:0] e;
    reg [9:0] ct_lo;
    begin
      ct_lo = `GPRP_REG_SPAN - {7'h0, t};
      e = 10'h0;
      xlate = 11'h0;
      case (md)
        `GPRP_MD_ABS: begin
          e = {3'h0, rn};
        end
        `GPRP_MD_IDX_OFF: begin
          e = {3'h0, rn} + {3'h0, off};
        end
        `GPRP_MD_IDX_AR: begin
          e = {3'h0, rn} + {1'b0, arx};
        end
        default: begin
          e = {3'h0, rn};
        end
      endcase
      // Shared modes fall back to relative mapping (temporaries or private) when not in dynamic mode
      if (shared_sel(md, dyn)) begin
        // Absolute space may run past globals into temporaries
        xlate = {1'b0, e};
      end else if ({3'h0, rn} >= ct_lo) begin
        // Each parity has its own section, so no bank clash; nothing
        // clears a section at clause start, so contents are undefined
        xlate = {1'b1, {2'h0, g} + (odd ? {7'h0, t} : 10'h0)
                 + ({3'h0, rn} - ct_lo)};
      end else begin
        xlate = {1'b0, {2'h0, g} + {6'h0, t, 1'b0} + {1'b0, wb}
                 + {3'h0, rn}};
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  assign cur_odd = issue_first ? 1'b1 : ~slot_odd_q;
  assign src_x = xlate(src_num, src_mode, src_off, addr_x_q, wave_base,
                       glb_eff, ct_cfg_q, cur_odd, dyn_q);
  assign dst_x = xlate(dst_num, dst_mode, dst_off, addr_x_q, wave_base,
                       glb_eff, ct_cfg_q, cur_odd, dyn_q);
  assign src_glb = shared_sel(src_mode, dyn_q) && (src_x[9:0] < {2'h0, glb_eff});
  assign dst_glb = shared_sel(dst_mode, dyn_q) && (dst_x[9:0] < {2'h0, glb_eff});
  // Only the last accepted write is tracked: visibility lags one group
  // Write from last group is not yet visible to the other wavefront
  assign stall = issue_valid && pend_v_q && (pend_odd_q != cur_odd) && src_glb
                 && (src_x[9:0] == pend_addr_q);
  assign issue_ready = ~stall;
  assign err_set = issue_valid && ~stall && (src_x[9:0] >= POOL || dst_x[9:0] >= POOL
                   || ((src_mode != `GPRP_MD_REL || dst_mode != `GPRP_MD_REL) && ~dyn_q));

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      slot_odd_q <= 1'b0;
      pend_v_q <= 1'b0;
      pend_odd_q <= 1'b0;
      pend_addr_q <= 10'h0;
      out_valid <= 1'b0;
      out_odd <= 1'b0;
      src_phys <= 10'h0;
      src_ct <= 1'b0;
      dst_phys <= 10'h0;
      dst_ct <= 1'b0;
      wr_mask <= {PIX{1'b0}};
      addr_x_q <= 9'h0;
    end else begin
      out_valid <= issue_valid && ~stall;
      // Retires one group later, which releases any stalled reader
      pend_v_q <= 1'b0;
      if (address_load_move) begin
        addr_x_q <= addr_x_data;
      end
      if (issue_valid && ~stall) begin
        slot_odd_q <= cur_odd;
        out_odd <= cur_odd;
        src_phys <= src_x[9:0];
        src_ct <= src_x[10];
        dst_phys <= dst_x[9:0];
        dst_ct <= dst_x[10];
        pend_v_q <= dst_we && dst_glb;
        pend_odd_q <= cur_odd;
        pend_addr_q <= dst_x[9:0];
        // Skipped or killed pixels never write, whatever the predicate
        wr_mask <= (pred_use ? pred_q : {PIX{1'b1}}) & active_q & valid_q
                   & {PIX{dst_we}};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel masks
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pred_q <= {PIX{1'b0}};
      pset_q <= {PIX{1'b0}};
      active_q <= {PIX{1'b1}};
      valid_q <= {PIX{1'b1}};
    end else begin
      if (wave_start) begin
        active_q <= {PIX{1'b1}};
        valid_q <= {PIX{1'b1}};
      end else begin
        if (clause_end && load_active) begin
          active_q <= pset_q;
        end
        if (pixel_kill_instruction) begin
          valid_q <= valid_q & ~kill_lanes;
        end
      end
      // Predicate lives for one clause only
      // Launch wins over a predicate write landing in the same cycle
      if (alu_clause_launch) begin
        pred_q <= {PIX{1'b0}};
      end else if (pred_we) begin
        pred_q <= (pred_q & ~pred_lanes) | (pred_val & pred_lanes);
      end
      // Deferred until clause end, held as latest result
      if (predicate_set_ops) begin
        pset_q <= (pred_q & ~pred_lanes) | (pred_val & pred_lanes);
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < PIX; gi = gi + 1) begin : g_pix
      always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          ps_q[2*gi+1:2*gi] <= `GPRP_PS_ACTIVE;
        end else if (wave_start) begin
          ps_q[2*gi+1:2*gi] <= `GPRP_PS_ACTIVE;
        end else if (pstate_we && pstate_lanes[gi]) begin
          ps_q[2*gi+1:2*gi] <= pstate_code;
        end
      end
    end
  endgenerate

  assign pred_mask = pred_q;
  assign active_mask = active_q;
  assign valid_mask = valid_q;
  assign pixel_state = ps_q;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states; read data sampled in setup
  // A write in the same access phase shows only on the next read
  function mapped;
    input [7:0] a;
    begin
      mapped = (a[1:0] == 2'h0) && (a <= `GPRP_VAL_HI_OFF);
    end
  endfunction

  assign setup = psel && ~penable;
  assign wr_acc = psel && penable && pwrite && mapped(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && ~mapped(paddr);

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      glb_cfg_q <= CFG_RST[`GPRP_CFG_GLB_MSB:`GPRP_CFG_GLB_LSB];
      ct_cfg_q <= CFG_RST[`GPRP_CFG_CT_MSB:`GPRP_CFG_CT_LSB];
      dyn_q <= CFG_RST[`GPRP_CFG_DYN_BIT];
      err_q <= 1'b0;
      prdata <= 32'h0;
    end else begin
      if (wr_acc && paddr == `GPRP_CFG_OFF) begin
        glb_cfg_q <= pwdata[`GPRP_CFG_GLB_MSB:`GPRP_CFG_GLB_LSB];
        ct_cfg_q <= (pwdata[`GPRP_CFG_CT_MSB:`GPRP_CFG_CT_LSB] > `GPRP_CT_MAX) ?
                    `GPRP_CT_MAX : pwdata[`GPRP_CFG_CT_MSB:`GPRP_CFG_CT_LSB];
        dyn_q <= pwdata[`GPRP_CFG_DYN_BIT];
      end
      // Set beats a write-one clear in the same cycle
      if (err_set) begin
        err_q <= 1'b1;
      end else if (wr_acc && paddr == `GPRP_STAT_OFF && pwdata[`GPRP_STAT_ERR_BIT]) begin
        err_q <= 1'b0;
      end
      if (setup) begin
        case (paddr)
          `GPRP_CFG_OFF: prdata <= {15'h0, dyn_q, 5'h0, ct_cfg_q, glb_cfg_q};
          `GPRP_STAT_OFF: prdata <= {15'h0, err_q, glb_eff, priv_avail[7:0]};
          `GPRP_PRED_LO_OFF: prdata <= pred_q[31:0];
          `GPRP_PRED_HI_OFF: prdata <= pred_q[PIX-1:32];
          `GPRP_ACT_LO_OFF: prdata <= active_q[31:0];
          `GPRP_ACT_HI_OFF: prdata <= active_q[PIX-1:32];
          `GPRP_VAL_LO_OFF: prdata <= valid_q[31:0];
          `GPRP_VAL_HI_OFF: prdata <= valid_q[PIX-1:32];
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// *** gprp_partition_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "gprp_consts.vh"
module gprp_partition_chk #(parameter PIX = 64) (
  // Clock, reset, bus
  input wire logic ref_clk, rstn, psel, penable, pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // Issue
  input wire logic issue_valid, issue_first, issue_ready, out_valid, out_odd,
  input wire logic [6:0] src_num, dst_num, dst_off,
  input wire logic [1:0] src_mode, dst_mode,
  input wire logic [9:0] src_phys, dst_phys,
  // Pixel control
  input wire logic wave_start, alu_clause_launch, clause_end, load_active, pred_we,
  input wire logic pixel_kill_instruction,
  input wire logic [PIX-1:0] kill_lanes, pred_mask, active_mask, valid_mask,
  input wire logic [2*PIX-1:0] pixel_state
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic dyn_q;
  wire logic acc = issue_valid && issue_ready;
  // Absolute modes only apply with dynamic mode on
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) dyn_q <= 1'h0;
    else if (psel && penable && pwrite && paddr == `GPRP_CFG_OFF) dyn_q <= pwdata[`GPRP_CFG_DYN_BIT];
  end
  AST_LAT: assert property (acc |=> out_valid)
    else $error("no out_valid");
  AST_ABS: assert property (acc && dyn_q && src_mode == `GPRP_MD_ABS
    |=> src_phys == {3'h0, $past(src_num)}) else $error("abs src");
  AST_IDX: assert property (acc && dyn_q && dst_mode == `GPRP_MD_IDX_OFF
    |=> dst_phys == {3'h0, $past(dst_num)} + {3'h0, $past(dst_off)}) else $error("idx dst");
  AST_STALL: assert property (!issue_ready |=> issue_ready)
    else $error("stall too long");
  AST_ODD: assert property (acc && issue_first |=> out_odd)
    else $error("first not odd");
  AST_KILL: assert property (pixel_kill_instruction && !wave_start
    |=> (valid_mask & $past(kill_lanes)) == '0) else $error("kill");
  AST_LAUNCH: assert property (alu_clause_launch && !pred_we |=> pred_mask == '0)
    else $error("pred kept");
  AST_DEFER: assert property (!(clause_end && load_active) && !wave_start
    |=> $stable(active_mask)) else $error("active early");
  AST_WAVE: assert property (wave_start |=> &valid_mask && pixel_state == '0)
    else $error("wave init");
  cover property (acc && dyn_q && src_mode == `GPRP_MD_ABS);
  cover property (!issue_ready);
  cover property (clause_end && load_active);
endmodule
bind gprp_partition gprp_partition_chk #(.PIX(PIX)) u_chk (
  .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .issue_valid(issue_valid), .issue_first(issue_first),
  .issue_ready(issue_ready), .out_valid(out_valid), .out_odd(out_odd), .src_num(src_num),
  .dst_num(dst_num), .dst_off(dst_off), .src_mode(src_mode), .dst_mode(dst_mode),
  .src_phys(src_phys), .dst_phys(dst_phys), .wave_start(wave_start),
  .alu_clause_launch(alu_clause_launch), .clause_end(clause_end), .load_active(load_active),
  .pred_we(pred_we), .pixel_kill_instruction(pixel_kill_instruction),
  .kill_lanes(kill_lanes), .pred_mask(pred_mask), .active_mask(active_mask),
  .valid_mask(valid_mask), .pixel_state(pixel_state));
`default_nettype wire

// *** gprp_partition_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "gprp_consts.vh"
module gprp_partition_tb;
  logic ref_clk = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h0, stl, g = 8'h10;
  logic [31:0] pwdata = 32'h0, prdata, rd, r, seed = 32'h9eb60685;
  logic pready, pslverr, er, issue_valid, issue_ready, issue_first, dst_we, pred_use = 1'h0;
  logic out_valid, out_odd, src_ct, dst_ct, odd;
  logic [42:0] fld, rq;
  logic [8:0] wave_base, addr_x_data = 9'h0;
  logic [6:0] src_num, src_off, dst_num, dst_off;
  logic [1:0] src_mode, dst_mode, pstate_code = 2'h0;
  logic [9:0] src_phys, dst_phys;
  logic [2:0] t = 3'h4;
  logic [63:0] p, k, wr_mask, pred_mask, active_mask, valid_mask;
  logic [63:0] pred_lanes = '0, pred_val = '0, kill_lanes = '0, pstate_lanes = '0;
  logic [127:0] pixel_state;
  logic address_load_move = 0, wave_start = 0, alu_clause_launch = 0, clause_end = 0;
  logic load_active = 0, pred_we = 0, predicate_set_ops = 0, pixel_kill_instruction = 0;
  logic pstate_we = 0;
  int miscompares = 0, cmp_count = 0;
  assign {issue_first, wave_base, src_num, src_mode, src_off, dst_num, dst_mode, dst_off,
    dst_we} = fld;
  always #20 ref_clk = ~ref_clk;
  gprp_partition u_dut (
    .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .issue_valid(issue_valid), .issue_first(issue_first), .issue_ready(issue_ready),
    .wave_base(wave_base), .src_num(src_num), .src_mode(src_mode), .src_off(src_off),
    .dst_num(dst_num), .dst_mode(dst_mode), .dst_off(dst_off), .dst_we(dst_we),
    .pred_use(pred_use), .address_load_move(address_load_move), .addr_x_data(addr_x_data),
    .out_valid(out_valid), .out_odd(out_odd), .src_phys(src_phys), .src_ct(src_ct),
    .dst_phys(dst_phys), .dst_ct(dst_ct), .wr_mask(wr_mask), .wave_start(wave_start),
    .alu_clause_launch(alu_clause_launch), .clause_end(clause_end),
    .load_active(load_active), .pred_we(pred_we), .pred_lanes(pred_lanes),
    .pred_val(pred_val), .predicate_set_ops(predicate_set_ops),
    .pixel_kill_instruction(pixel_kill_instruction), .kill_lanes(kill_lanes),
    .pstate_we(pstate_we), .pstate_lanes(pstate_lanes), .pstate_code(pstate_code),
    .pred_mask(pred_mask), .active_mask(active_mask), .valid_mask(valid_mask),
    .pixel_state(pixel_state));
  gprp_alu_model u_alu (.clk(ref_clk), .rstn(rstn), .issue_ready(issue_ready),
    .issue_valid(issue_valid), .fld(fld), .stalls(stl));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] stat(input logic [7:0] gg);
    logic [9:0] lo;
    if (gg > 8'h80 - {4'h0, t, 1'h0}) gg = 8'h80 - {4'h0, t, 1'h0};
    lo = 10'h100 - {2'h0, gg} - {6'h0, t, 1'h0};
    return {gg, lo[7:0]};
  endfunction
  // Operand is {number, mode, offset}; result is {temp flag, physical}
  function automatic logic [10:0] phys(input logic [15:0] op);
    if (op[8:7] == `GPRP_MD_ABS) return {4'h0, op[15:9]};
    if (op[8:7] == `GPRP_MD_IDX_OFF) return {4'h0, op[15:9]} + {4'h0, op[6:0]};
    if (op[8:7] == `GPRP_MD_IDX_AR) return {4'h0, op[15:9]} + {2'h0, addr_x_data};
    if ({1'h0, op[15:9]} >= 8'h80 - t)
      return {1'h1, {2'h0, g} + (odd ? {7'h0, t} : 10'h0) + {3'h0, op[15:9]} + t - 10'h80};
    return {1'h0, {2'h0, g} + {6'h0, t, 1'h0} + {1'h0, rq[41:33]} + {3'h0, op[15:9]}};
  endfunction
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] e, input logic [63:0] a, input string nm);
    cmp_count++;
    if (a !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, a);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge ref_clk);
    penable <= 1'h1;
    for (n = 0; n < 50 && !(n > 0 && pready); n++) @(posedge ref_clk);
    if (n == 50) begin
      miscompares++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  // Wait until the model has nothing left to issue
  task automatic idle();
    for (int n = 0; n < 50; n++) begin
      @(negedge ref_clk);
      if (!issue_valid && u_alu.q.size() == 0) return;
    end
    miscompares++;
    conclude();
  endtask
  task automatic step();
    @(posedge ref_clk);
    {address_load_move, wave_start, alu_clause_launch, clause_end, load_active, pred_we,
      predicate_set_ops, pixel_kill_instruction, pstate_we} <= 9'h0;
    @(negedge ref_clk);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1'h1;
    apb(1'h1, `GPRP_CFG_OFF, 32'h0000_04c8);
    apb(1'h0, `GPRP_STAT_OFF, 32'h0);
    chk(stat(8'hc8), rd[15:0], "clamp");
    @(negedge ref_clk);
    u_alu.q.push_back({1'h1, 9'h0, 7'h05, `GPRP_MD_ABS, 7'h0, 17'h0});
    idle();
    // Globals off: number 5 lands above 120 globals and two 4-deep temp sections
    chk(10'h085, src_phys, "dyn off");
    apb(1'h0, `GPRP_STAT_OFF, 32'h0);
    chk(1'h1, rd[16], "err");
    apb(1'h1, `GPRP_STAT_OFF, 32'h0001_0000);
    apb(1'h1, `GPRP_CFG_OFF, 32'h0001_0410);
    apb(1'h0, `GPRP_STAT_OFF, 32'h0);
    chk({1'h0, stat(g)}, rd[16:0], "stat");
    apb(1'h0, 8'h40, 32'h0);
    chk({1'h1, 32'h0}, {er, rd}, "unmapped");
    r = rnd();
    @(posedge ref_clk);
    {address_load_move, addr_x_data} <= {4'h8, r[5:0]};
    step();
    $display("test config done");
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      p = {rnd(), rnd()};
      rq = {i == 0 || r[2:0] == 3'h0, 3'h0, r[8:3], r[15:9], r[17:16], 3'h0, r[21:18],
        r[28:22], p[1:0], 3'h0, p[5:2], 1'h0};
      if (i < 4) rq[32:24] = {7'h7c + i[6:0], 2'h0};
      odd = rq[42] | ~odd;
      u_alu.q.push_back(rq);
      idle();
      chk(odd, out_odd, "parity");
      chk(phys(rq[32:17]), {src_ct, src_phys}, "src");
      chk(phys(rq[16:1]), {dst_ct, dst_phys}, "dst");
    end
    r = {24'h0, stl};
    u_alu.q.push_back({1'h1, 25'h0, 7'h05, `GPRP_MD_ABS, 7'h0, 1'h1});
    u_alu.q.push_back({1'h0, 9'h0, 7'h05, `GPRP_MD_ABS, 7'h0, 17'h0});
    idle();
    chk(8'h1, stl - r[7:0], "stall");
    chk(10'h5, src_phys, "abs");
    $display("test operand map done");
    @(posedge ref_clk) wave_start <= 1'h1;
    step();
    chk(~64'h0, active_mask, "active");
    k = {rnd(), rnd()};
    @(posedge ref_clk);
    {kill_lanes, pixel_kill_instruction} <= {k, 1'h1};
    step();
    chk(~k, valid_mask, "kill");
    @(posedge ref_clk) alu_clause_launch <= 1'h1;
    step();
    chk(64'h0, pred_mask, "launch");
    p = {rnd(), rnd()};
    @(posedge ref_clk);
    {pred_lanes, pred_val, pred_we, predicate_set_ops} <= {~64'h0, p, 2'h3};
    step();
    chk(p, pred_mask, "pred");
    chk(~64'h0, active_mask, "deferred");
    @(posedge ref_clk);
    {clause_end, load_active} <= 2'h3;
    step();
    chk(p, active_mask, "load");
    apb(1'h0, `GPRP_ACT_HI_OFF, 32'h0);
    chk(p[63:32], rd, "act hi");
    @(posedge ref_clk) pred_use <= 1'h1;
    @(negedge ref_clk);
    u_alu.q.push_back({1'h0, 41'h0, 1'h1});
    idle();
    // Predicate, active and valid all gate the write
    chk(p & ~k, wr_mask, "wr mask");
    for (int c = 0; c < 4; c++) begin
      @(posedge ref_clk);
      {pstate_lanes, pstate_code, pstate_we} <= {64'h1 << (c * 9), c[1:0], 1'h1};
      step();
      chk(c, pixel_state[c * 18 +: 2], "pstate");
    end
    $display("test masks done");
    conclude();
  end
endmodule
`default_nettype wire
